/* include/dmr_map.svh */
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH

// highest address of the lower internal ram, reachable both ways
`define DMR_LOW_TOP 8'h7f
// high address byte of the on-chip expansion ram in the external space
`define DMR_XRAM_TOP_HIGH 8'h00
// clocks between free-running latch strobe pulses while not suppressed
`define DMR_ALE_PERIOD 3'h6
// clocks the read or write strobe stays low in an external cycle
`define DMR_STROBE_CYC 3'h2
// reset and idle value of the read and write strobe pins
`define DMR_PIN_IDLE 1'h1
`define DMR_BYTE_ZERO 8'h00

`endif

/* include/dmr_pkg.sv */
package dmr_pkg;

    // how the core addresses the data byte
    typedef enum logic [2:0] {
        DMR_DIRECT,
        DMR_INDIRECT,
        DMR_STACK,
        DMR_XMOVE_BYTE,
        DMR_XMOVE_WIDE
    } dmr_kind_t;

    // one access request from the core
    typedef struct packed {
        dmr_kind_t kind;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dmr_req_t;

    // access sequencer states
    typedef enum logic [2:0] {
        DMR_IDLE,
        DMR_ADDR,
        DMR_STROBE,
        DMR_END,
        DMR_SFR
    } dmr_state_t;

    // all state of the router
    typedef struct packed {
        dmr_state_t state;
        logic ready;
        logic resp_valid;
        logic [7:0] resp_rdata;
        logic sfr_strobe;
        logic sfr_write;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
        logic [7:0] pzero_out;
        logic pzero_oe;
        logic [7:0] ptwo_out;
        logic wr_n;
        logic rd_n;
        logic ale;
        logic [2:0] ale_div;
        logic [2:0] cnt;
        logic ext_write;
        logic wide;
    } dmr_regs_t;

endpackage : dmr_pkg

/* rtl/dmr_router.sv */
`timescale 1ns/1ps
`include "dmr_map.svh"
// How it works
// - lower 128 bytes reached direct and indirect
// - upper 128 bytes reached indirect only
// - direct above 7fh goes to sfr space
// - indirect above 7fh goes to upper ram
// - 256 byte on-chip expansion ram exists
// - bypass clear, byte pointer move hits expansion ram
// - expansion ram access leaves bus pins quiet
// - port two keeps its latch during expansion access
// - wide pointer above ffh runs external cycle
// - bypass set, byte pointer drives 8-bit address
// - bypass set, wide pointer high byte on port two
// - external moves pulse write or read strobe
// - stack only reaches the 256 internal bytes
// - suppress bit holds latch strobe inactive
// - suppressed strobe still pulses per external access
module dmr_router (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire dmr_pkg::dmr_req_t req,
    output logic req_ready,
    output logic resp_valid,
    output logic [7:0] resp_rdata,
    input wire logic expansion_ram_bypass,
    input wire logic latch_strobe_suppress,
    input wire logic [7:0] port_two_latch,
    output logic sfr_strobe,
    output logic sfr_write,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] port_zero_in,
    output logic [7:0] port_zero_out,
    output logic port_zero_oe,
    output logic [7:0] port_two,
    output logic write_strobe_pin_n,
    output logic read_strobe_pin_n,
    output logic ale
);

    ////////////////////////////////////////////////////////////////////
    // storage

    // lower and upper internal ram, and the on-chip expansion ram
    logic [7:0] low_ram [0:127];
    logic [7:0] up_ram [0:127];
    logic [7:0] onchip_xdata_ram [0:255];

    dmr_pkg::dmr_regs_t st;
    dmr_pkg::dmr_regs_t next_st;

    // write controls for the arrays
    logic low_we;
    logic up_we;
    logic xram_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;

    // decoded target of the offered request
    logic take;
    logic is_ext;
    logic is_xram;
    logic is_sfr;
    logic is_up;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////
    // target decode

    // sort the offered request into one of five places
    always_comb
    begin
        take = req_valid && st.ready;
        mem_addr = req.addr[7:0];
        mem_wdata = req.wdata;
        is_ext = 1'b0;
        is_xram = 1'b0;
        is_sfr = 1'b0;
        is_up = 1'b0;
        case (req.kind)
            dmr_pkg::DMR_DIRECT:
            begin
                // direct above the low area is the sfr space
                is_sfr = req.addr[7:0] > `DMR_LOW_TOP;
            end
            dmr_pkg::DMR_INDIRECT, dmr_pkg::DMR_STACK:
            begin
                // indirect and stack see the full 256 internal bytes
                is_up = req.addr[7:0] > `DMR_LOW_TOP;
            end
            dmr_pkg::DMR_XMOVE_BYTE:
            begin
                // byte pointer: expansion ram unless bypassed
                is_ext = expansion_ram_bypass;
                is_xram = !expansion_ram_bypass;
            end
            dmr_pkg::DMR_XMOVE_WIDE:
            begin
                // wide pointer: expansion ram only in its first page
                is_xram = !expansion_ram_bypass &&
                    (req.addr[15:8] == `DMR_XRAM_TOP_HIGH);
                is_ext = !is_xram;
            end
            default:
            begin
                is_sfr = 1'b0;
            end
        endcase
        // arrays written only for taken internal and expansion ram stores
        low_we = take && req.write && !is_ext && !is_xram && !is_sfr &&
            !is_up;
        up_we = take && req.write && is_up;
        xram_we = take && req.write && is_xram;
        // read byte from the selected array
        if (is_xram)
        begin
            rd_byte = onchip_xdata_ram[mem_addr];
        end
        else if (is_up)
        begin
            rd_byte = up_ram[mem_addr[6:0]];
        end
        else
        begin
            rd_byte = low_ram[mem_addr[6:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // array writes

    // memories hold no reset, they keep contents like real ram
    always_ff @(posedge clk)
    begin
        if (low_we)
        begin
            low_ram[mem_addr[6:0]] <= mem_wdata;
        end
        if (up_we)
        begin
            up_ram[mem_addr[6:0]] <= mem_wdata;
        end
        if (xram_we)
        begin
            onchip_xdata_ram[mem_addr] <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer

    // next state of the router and its bus pins
    always_comb
    begin
        next_st = st;
        next_st.resp_valid = 1'b0;
        next_st.sfr_strobe = 1'b0;
        // free-running divider for idle latch strobe pulses
        if (st.ale_div == `DMR_ALE_PERIOD - 3'h1)
        begin
            next_st.ale_div = 3'h0;
        end
        else
        begin
            next_st.ale_div = st.ale_div + 3'h1;
        end
        // port two follows its latch unless a wide cycle owns it
        if (!st.wide)
        begin
            next_st.ptwo_out = port_two_latch;
        end
        case (st.state)
            dmr_pkg::DMR_IDLE:
            begin
                // idle strobe pulses only when not suppressed
                next_st.ale = !latch_strobe_suppress &&
                    (st.ale_div == 3'h0);
                if (take && is_ext)
                begin
                    // address phase: strobe pulses even if suppressed
                    next_st.state = dmr_pkg::DMR_ADDR;
                    next_st.ready = 1'b0;
                    next_st.ale = 1'b1;
                    next_st.pzero_out = req.addr[7:0];
                    next_st.pzero_oe = 1'b1;
                    next_st.ext_write = req.write;
                    next_st.sfr_wdata = req.wdata;
                    next_st.wide = (req.kind == dmr_pkg::DMR_XMOVE_WIDE);
                    if (req.kind == dmr_pkg::DMR_XMOVE_WIDE)
                    begin
                        next_st.ptwo_out = req.addr[15:8];
                    end
                end
                else if (take && is_sfr)
                begin
                    // hand the access to the sfr bank
                    next_st.state = dmr_pkg::DMR_SFR;
                    next_st.ready = 1'b0;
                    next_st.sfr_strobe = 1'b1;
                    next_st.sfr_write = req.write;
                    next_st.sfr_addr = req.addr[7:0];
                    next_st.sfr_wdata = req.wdata;
                end
                else if (take)
                begin
                    // internal or expansion ram: pins untouched
                    next_st.resp_valid = 1'b1;
                    next_st.resp_rdata = req.write ? `DMR_BYTE_ZERO :
                        rd_byte;
                end
            end
            dmr_pkg::DMR_ADDR:
            begin
                // drop the strobe, assert read or write
                next_st.ale = 1'b0;
                next_st.state = dmr_pkg::DMR_STROBE;
                next_st.cnt = `DMR_STROBE_CYC - 3'h1;
                next_st.pzero_oe = st.ext_write;
                next_st.pzero_out = st.sfr_wdata;
                next_st.wr_n = !st.ext_write;
                next_st.rd_n = st.ext_write;
            end
            dmr_pkg::DMR_STROBE:
            begin
                // hold the strobe, then sample and release
                if (st.cnt == 3'h0)
                begin
                    next_st.wr_n = `DMR_PIN_IDLE;
                    next_st.rd_n = `DMR_PIN_IDLE;
                    next_st.state = dmr_pkg::DMR_END;
                    next_st.resp_valid = 1'b1;
                    next_st.resp_rdata = st.ext_write ? `DMR_BYTE_ZERO :
                        port_zero_in;
                end
                else
                begin
                    next_st.cnt = st.cnt - 3'h1;
                end
            end
            dmr_pkg::DMR_END:
            begin
                // float port zero, give port two back to its latch
                next_st.pzero_oe = 1'b0;
                next_st.wide = 1'b0;
                next_st.ptwo_out = port_two_latch;
                next_st.ready = 1'b1;
                next_st.state = dmr_pkg::DMR_IDLE;
            end
            dmr_pkg::DMR_SFR:
            begin
                // sfr bank answers one cycle after the strobe
                // an idle latch pulse must not stretch into this cycle
                next_st.ale = 1'b0;
                next_st.resp_valid = 1'b1;
                next_st.resp_rdata = st.sfr_write ? `DMR_BYTE_ZERO :
                    sfr_rdata;
                next_st.ready = 1'b1;
                next_st.state = dmr_pkg::DMR_IDLE;
            end
            default:
            begin
                next_st.state = dmr_pkg::DMR_IDLE;
                next_st.ready = 1'b1;
            end
        endcase
    end

    // register all state, synchronous reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.state <= dmr_pkg::DMR_IDLE;
            st.ready <= 1'b1;
            st.wr_n <= `DMR_PIN_IDLE;
            st.rd_n <= `DMR_PIN_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign req_ready = st.ready;
    assign resp_valid = st.resp_valid;
    assign resp_rdata = st.resp_rdata;
    assign sfr_strobe = st.sfr_strobe;
    assign sfr_write = st.sfr_write;
    assign sfr_addr = st.sfr_addr;
    assign sfr_wdata = st.sfr_wdata;
    assign port_zero_out = st.pzero_out;
    assign port_zero_oe = st.pzero_oe;
    assign port_two = st.ptwo_out;
    assign write_strobe_pin_n = st.wr_n;
    assign read_strobe_pin_n = st.rd_n;
    assign ale = st.ale;

endmodule : dmr_router

/* tb/dmr_router_checker.sv */
`timescale 1ns/1ps
// watches routing and external bus timing at the router ports
module dmr_router_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire dmr_pkg::dmr_req_t req,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic expansion_ram_bypass,
    input wire logic latch_strobe_suppress,
    input wire logic [7:0] port_two_latch,
    input wire logic sfr_strobe,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] port_zero_out,
    input wire logic port_zero_oe,
    input wire logic [7:0] port_two,
    input wire logic write_strobe_pin_n,
    input wire logic read_strobe_pin_n,
    input wire logic ale
);
    // request classes seen at the take edge
    logic take;
    logic ptr;
    logic xmove;
    logic ext;
    logic quiet;
    assign take = req_valid && req_ready;
    assign ptr = req.kind == dmr_pkg::DMR_XMOVE_WIDE;
    assign xmove = ptr || req.kind == dmr_pkg::DMR_XMOVE_BYTE;
    // external cycle: bypass set, or wide pointer above the first page
    assign ext = take && xmove && (expansion_ram_bypass
        || ptr && req.addr[15:8] != 8'h00);
    assign quiet = write_strobe_pin_n && read_strobe_pin_n;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // steps of one external cycle
    sequence s_addr;
        ale && port_zero_oe && !req_ready;
    endsequence
    sequence s_strobe;
        (!read_strobe_pin_n ^ !write_strobe_pin_n) [*2];
    endsequence
    sequence s_done;
        resp_valid && quiet;
    endsequence

    AST_DIRECT_LOW: assert property (take && !req.addr[7] &&
        req.kind == dmr_pkg::DMR_DIRECT |=> resp_valid && !sfr_strobe)
        else $error("direct low access not answered next cycle");
    AST_INDIRECT: assert property (take &&
        req.kind inside {dmr_pkg::DMR_INDIRECT, dmr_pkg::DMR_STACK}
        |=> resp_valid && !sfr_strobe && quiet)
        else $error("indirect access left internal ram");
    AST_SFR: assert property (take && req.addr[7] &&
        req.kind == dmr_pkg::DMR_DIRECT |=> sfr_strobe
        && sfr_addr == $past(req.addr[7:0]) ##1 resp_valid)
        else $error("direct high access missed sfr space");
    AST_XRAM_QUIET: assert property (take && xmove && !ext
        |=> resp_valid && quiet && $stable(port_zero_out)
        && $stable(port_zero_oe))
        else $error("expansion ram access disturbed the bus");
    AST_XRAM_PTWO: assert property (take && xmove && !ext
        |=> port_two == $past(port_two_latch))
        else $error("port two lost latch during expansion access");
    AST_EXT_CYCLE: assert property (ext
        |=> s_addr ##1 s_strobe ##1 s_done)
        else $error("external cycle out of order");
    AST_EXT_ADDR: assert property (ext |=>
        port_zero_out == $past(req.addr[7:0]) && port_two == ($past(ptr)
        ? $past(req.addr[15:8]) : $past(port_two_latch)))
        else $error("external address wrong on ports");
    AST_EXT_DIR: assert property (ext && req.write
        |=> ##1 !write_strobe_pin_n && read_strobe_pin_n)
        else $error("store did not use write strobe");
    AST_ALE_SUPP: assert property (ale &&
        latch_strobe_suppress && $past(latch_strobe_suppress) |-> $past(ext))
        else $error("latch strobe pulsed while suppressed");
endmodule : dmr_router_checker

bind dmr_router dmr_router_checker chk_u (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .expansion_ram_bypass(expansion_ram_bypass),
    .latch_strobe_suppress(latch_strobe_suppress),
    .port_two_latch(port_two_latch), .sfr_strobe(sfr_strobe),
    .sfr_addr(sfr_addr), .port_zero_out(port_zero_out),
    .port_zero_oe(port_zero_oe), .port_two(port_two),
    .write_strobe_pin_n(write_strobe_pin_n),
    .read_strobe_pin_n(read_strobe_pin_n), .ale(ale));

/* tb/dmr_ext_mem.sv */
`timescale 1ns/1ps
// external data memory on the multiplexed address and data bus
module dmr_ext_mem (
    input wire logic clk,
    input wire logic ale,
    input wire logic [7:0] port_zero_out,
    input wire logic [7:0] port_two,
    input wire logic write_strobe_pin_n,
    input wire logic read_strobe_pin_n,
    output logic [7:0] port_zero_in
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h00;
    // latch low address, store on write strobe
    always @(posedge clk)
    begin
        if (ale) lat <= port_zero_out;
        if (!write_strobe_pin_n) mem[{port_two, lat}] <= port_zero_out;
        if (!read_strobe_pin_n) last <= mem[{port_two, lat}];
    end
    // released bus shows the inverse of the last byte read under the read strobe
    assign port_zero_in = read_strobe_pin_n ? ~last : mem[{port_two, lat}];
endmodule : dmr_ext_mem

/* tb/dmr_router_bench.sv */
`timescale 1ns/1ps
// drives core requests and checks read-back values
module dmr_router_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    dmr_pkg::dmr_req_t req = '0;
    logic bypass = 1'b0;
    logic suppress = 1'b1;
    logic [7:0] ptwo_latch = 8'h12;
    logic req_ready, resp_valid, wr_n, rd_n, ale;
    logic [7:0] resp_rdata, pzero_out, pzero_in, ptwo;
    logic sfr_wr;
    logic [7:0] sfr_wd;
    logic [7:0] rd;
    int na;
    int error_cnt = 0;
    int check_count = 0;

    always #2.5 clk = ~clk;

    dmr_router dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .expansion_ram_bypass(bypass),
        .latch_strobe_suppress(suppress), .port_two_latch(ptwo_latch),
        .sfr_strobe(), .sfr_write(sfr_wr), .sfr_addr(), .sfr_wdata(sfr_wd),
        .sfr_rdata(8'h3c), .port_zero_in(pzero_in),
        .port_zero_out(pzero_out),
        .port_zero_oe(), .port_two(ptwo), .write_strobe_pin_n(wr_n),
        .read_strobe_pin_n(rd_n), .ale(ale));

    dmr_ext_mem mem_u (.clk(clk), .ale(ale), .port_zero_out(pzero_out),
        .port_two(ptwo), .write_strobe_pin_n(wr_n),
        .read_strobe_pin_n(rd_n), .port_zero_in(pzero_in));

    // compare and count
    task chk(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one request, held until taken, answer into rd
    task acc(input dmr_pkg::dmr_kind_t k, input logic w,
        input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{k, w, a, d};
        n = 0;
        do @(posedge clk); while (!req_ready && ++n < 20);
        req_valid <= 1'b0;
        n = 0;
        do @(posedge clk); while (resp_valid !== 1'b1 && ++n < 20);
        rd = resp_rdata;
        chk("answer", {7'h00, resp_valid}, 8'h01);
    endtask : acc

    // count latch strobe pulses over n clocks
    task cnt_ale(input int n);
        na = 0;
        repeat (n)
        begin
            @(posedge clk);
            if (ale === 1'b1) na++;
        end
    endtask : cnt_ale

    // lower ram both ways
    task t_low;
        acc(dmr_pkg::DMR_DIRECT, 1'b1, 16'h007f, 8'h5e);
        acc(dmr_pkg::DMR_INDIRECT, 1'b0, 16'h007f, 8'h00);
        chk("low ram", rd, 8'h5e);
        $display("test low done");
    endtask : t_low

    // upper ram, sfr space and stack
    task t_upper;
        acc(dmr_pkg::DMR_INDIRECT, 1'b1, 16'h0080, 8'ha5);
        acc(dmr_pkg::DMR_DIRECT, 1'b1, 16'h0080, 8'h11);
        chk("sfr wdata", sfr_wd, 8'h11);
        chk("sfr write", {7'h00, sfr_wr}, 8'h01);
        acc(dmr_pkg::DMR_DIRECT, 1'b0, 16'h0080, 8'h00);
        chk("sfr read", rd, 8'h3c);
        chk("sfr read flag", {7'h00, sfr_wr}, 8'h00);
        acc(dmr_pkg::DMR_INDIRECT, 1'b0, 16'h0080, 8'h00);
        chk("upper ram", rd, 8'ha5);
        acc(dmr_pkg::DMR_STACK, 1'b1, 16'h00ff, 8'hc3);
        acc(dmr_pkg::DMR_INDIRECT, 1'b0, 16'h00ff, 8'h00);
        chk("stack", rd, 8'hc3);
        $display("test upper done");
    endtask : t_upper

    // expansion ram and external bus
    task t_xdata;
        acc(dmr_pkg::DMR_XMOVE_BYTE, 1'b1, 16'h00a0, 8'h5a);
        acc(dmr_pkg::DMR_XMOVE_WIDE, 1'b0, 16'h00a0, 8'h00);
        chk("expansion ram", rd, 8'h5a);
        acc(dmr_pkg::DMR_XMOVE_WIDE, 1'b1, 16'h1234, 8'h77);
        acc(dmr_pkg::DMR_XMOVE_WIDE, 1'b0, 16'h1234, 8'h00);
        chk("external wide", rd, 8'h77);
        bypass <= 1'b1;
        acc(dmr_pkg::DMR_XMOVE_BYTE, 1'b1, 16'h00a0, 8'h3b);
        acc(dmr_pkg::DMR_XMOVE_WIDE, 1'b0, 16'h12a0, 8'h00);
        chk("external paged", rd, 8'h3b);
        bypass <= 1'b0;
        acc(dmr_pkg::DMR_XMOVE_WIDE, 1'b0, 16'h00a0, 8'h00);
        chk("expansion kept", rd, 8'h5a);
        $display("test xdata done");
    endtask : t_xdata

    // latch strobe suppression
    task t_ale;
        cnt_ale(20);
        chk("ale idle off", na[7:0], 8'h00);
        fork
            acc(dmr_pkg::DMR_XMOVE_WIDE, 1'b0, 16'h1234, 8'h00);
            cnt_ale(10);
        join
        chk("ale ext pulse", na[7:0], 8'h01);
        chk("external again", rd, 8'h77);
        suppress <= 1'b0;
        @(posedge clk);
        cnt_ale(12);
        chk("ale free run", na[7:0], 8'h02);
        $display("test ale done");
    endtask : t_ale

    // verdict and end of run
    task results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_low;
        t_upper;
        t_xdata;
        t_ale;
        results;
    end

    // watchdog well beyond the expected run
    initial
    begin
        #20000;
        error_cnt++;
        results;
    end
endmodule : dmr_router_bench
